// *** verilog/cpu_interrupt_sequencing.sv ***
// Interrupt sequencing, stack pointer and condition flags of the core
`timescale 1ns/10ps
`default_nettype none
`include "irq_seq_consts.svh"
//
// Contract
// - Program counter is 16 bits, holds next fetch address.
// - Reset and reload-stack-pointer instruction set pointer to top of stack.
// - Pointer names next free slot; post-decrement push, pre-increment pull.
// - Stack address is 00000011 above six pointer bits, range C0 to FF.
// - Sixty-four byte stack; overflow wraps and overwrites oldest bytes.
// - Call pushes two bytes; interrupt entry pushes five bytes.
// - Five flag bits; half carry from bit 3 into bit 4 on adds.
// - Mask flag blocks maskable sources; requests stay latched meanwhile.
// - Negative and zero flags follow the last result.
// - Carry records ALU carry or borrow, also shifts and bit tests.
// - Entry pushes registers and sets mask; return restores and resumes.
// - Hardware interrupts wait for the current instruction to finish.
// - At each boundary take a source only if unmasked and enabled.
// - External request wins over timer and serial requests.
// - Software interrupt ignores mask and vectors through 3FFC.
// - Falling edge on the pin latches a synchronized request; vector 3FFA.
// - Port B pins with pull-ups act as extra external sources.
// - Sensitivity is edge-and-level or edge-only, chosen by option bit.
// - External latch clears early in service so one more pulse latches.
// - Timer interrupt from three enabled flags; vector 3FF8.
// - Async serial interrupt from five enabled flags; vector 3FF6.
// - Sync serial interrupt from two flags under one enable; vector 3FF4.
module cpu_interrupt_sequencing #(
	parameter int PORTB_WIDTH = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic i_irq_pin_n,
	input wire logic [PORTB_WIDTH-1:0] i_portb_pin,
	input wire logic [PORTB_WIDTH-1:0] i_portb_pullup_en,
	input wire logic i_compat_sel,
	input wire logic i_soft_edge_only,
	input wire logic i_prog_edge_select_bit,
	input wire irq_seq_pkg::timer_irq_s i_timer,
	input wire irq_seq_pkg::async_irq_s i_async,
	input wire irq_seq_pkg::sync_irq_s i_sync,
	input wire logic i_insn_done,
	input wire logic [15:0] i_next_pc,
	input wire logic i_pc_advance,
	input wire logic i_swi,
	input wire logic i_rti,
	input wire logic i_call,
	input wire logic [15:0] i_call_target,
	input wire logic i_reload_sp,
	input wire logic i_push,
	input wire logic i_pull,
	input wire logic [7:0] i_acc,
	input wire logic [7:0] i_index,
	input wire logic [7:0] i_mem_rdata,
	input wire irq_seq_pkg::alu_flags_s i_alu,
	input wire logic i_ccr_wr,
	input wire logic [4:0] i_ccr_wdata,
	output logic [15:0] o_pc,
	output logic [15:0] o_mem_addr,
	output logic [7:0] o_mem_wdata,
	output logic o_mem_wr,
	output logic o_mem_rd,
	output logic [7:0] o_restore_acc,
	output logic [7:0] o_restore_index,
	output logic o_restore_valid,
	output logic [4:0] o_condition_flags,
	output logic o_pin_level,
	output logic o_busy
);
	irq_seq_pkg::seq_state_e state_ff, nxt_state;
	logic [15:0] pc_ff, nxt_pc;
	logic [5:0] sp_ff, nxt_sp;
	logic [4:0] ccr_ff, nxt_ccr;
	logic [2:0] cnt_ff, nxt_cnt;
	logic [15:0] vec_ff, nxt_vec;
	logic [7:0] vhi_ff, nxt_vhi;
	logic [7:0] racc_ff, nxt_racc;
	logic [7:0] rix_ff, nxt_rix;
	logic rvalid_ff, nxt_rvalid;
	logic [15:0] addr_ff, nxt_addr;
	logic [7:0] wdata_ff, nxt_wdata;
	logic wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [15:0] call_pc_ff, nxt_call_pc;
	logic swi_pend_ff, nxt_swi_pend;
	logic [PORTB_WIDTH:0] sync1_ff, sync2_ff, prev_ff;
	logic ext_latch_ff, nxt_ext_latch;
	wire [PORTB_WIDTH:0] line_low;
	wire [PORTB_WIDTH:0] fall;
	wire any_fall, any_low, edge_only, ext_req, timer_req, async_req;
	wire sync_req, masked, take_ext, take_hw, clear_ext;
	wire [15:0] hw_vec;
	wire [4:0] alu_ccr;
	wire [8:0] sum9;
	wire [4:0] sum5;
	wire [5:0] sp_dec, sp_inc;

	genvar g;
	// Pin lines pass two flip-flops before any logic reads them
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_ff <= '1;
			sync2_ff <= '1;
			prev_ff <= '1;
		end else if (i_clk_en) begin
			sync1_ff <= {i_irq_pin_n, i_portb_pin};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end
	generate
		for (g = 0; g <= PORTB_WIDTH; g = g + 1) begin : g_line
			if (g == PORTB_WIDTH) begin : g_irq
				assign line_low[g] = ~sync2_ff[g];
			end else begin : g_pb
				assign line_low[g] = ~sync2_ff[g] & i_portb_pullup_en[g];
			end
			assign fall[g] = line_low[g] & prev_ff[g];
		end
	endgenerate
	assign any_fall = |fall;
	assign any_low = |line_low;
	assign o_pin_level = ~any_low;
	// Option source depends on compatibility mode
	assign edge_only = i_compat_sel ? i_prog_edge_select_bit :
		i_soft_edge_only;
	// Level mode keeps request alive while a line is held low
	assign ext_req = ext_latch_ff | (~edge_only & any_low);
	assign timer_req = (i_timer.capture_flag & i_timer.capture_int_enable) |
		(i_timer.compare_flag & i_timer.compare_int_enable) |
		(i_timer.overflow_flag & i_timer.overflow_int_enable);
	assign async_req = ((i_async.transmit_empty_flag |
		i_async.transmit_complete_flag) & i_async.transmit_int_enable) |
		((i_async.receive_full_flag | i_async.overrun_flag) &
		i_async.receive_int_enable) |
		(i_async.idle_flag & i_async.idle_int_enable);
	assign sync_req = (i_sync.transfer_complete_flag |
		i_sync.mode_fault_flag) & i_sync.sync_serial_int_enable;
	assign masked = ccr_ff[`CCR_BIT_I];
	assign take_ext = ~masked & ext_req;
	assign take_hw = ~masked & (ext_req | timer_req | async_req | sync_req);
	assign hw_vec = ext_req ? `VEC_EXT :
		timer_req ? `VEC_TIMER :
		async_req ? `VEC_ASYNC : `VEC_SYNC;
	assign clear_ext = (state_ff == irq_seq_pkg::ST_PUSH) &&
		(cnt_ff == 3'h0) && (vec_ff == `VEC_EXT);
	// Set wins over clear so a pulse during service is not lost
	assign nxt_ext_latch = any_fall | (ext_latch_ff & ~clear_ext);

	assign sum9 = {1'b0, i_alu.a} + {1'b0, i_alu.b} +
		{8'h00, i_alu.carry_in};
	assign sum5 = {1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]} +
		{4'h0, i_alu.carry_in};
	assign alu_ccr[`CCR_BIT_H] = i_alu.upd_h ? sum5[4] :
		ccr_ff[`CCR_BIT_H];
	assign alu_ccr[`CCR_BIT_I] = ccr_ff[`CCR_BIT_I];
	assign alu_ccr[`CCR_BIT_N] = i_alu.upd_nz ? i_alu.result[7] :
		ccr_ff[`CCR_BIT_N];
	assign alu_ccr[`CCR_BIT_Z] = i_alu.upd_nz ? (i_alu.result == 8'h00) :
		ccr_ff[`CCR_BIT_Z];
	assign alu_ccr[`CCR_BIT_C] = i_alu.upd_c ? i_alu.c_value :
		ccr_ff[`CCR_BIT_C];
	// Six-bit pointer arithmetic wraps on its own
	assign sp_dec = sp_ff - 6'h01;
	assign sp_inc = sp_ff + 6'h01;

	always_comb begin
		nxt_state = state_ff;
		nxt_pc = pc_ff;
		nxt_sp = sp_ff;
		nxt_ccr = ccr_ff;
		nxt_cnt = cnt_ff;
		nxt_vec = vec_ff;
		nxt_vhi = vhi_ff;
		nxt_racc = racc_ff;
		nxt_rix = rix_ff;
		nxt_rvalid = 1'b0;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_wr = 1'b0;
		nxt_rd = 1'b0;
		nxt_call_pc = call_pc_ff;
		nxt_swi_pend = swi_pend_ff;
		case (state_ff)
			irq_seq_pkg::ST_RESET: begin
				nxt_vec = `VEC_RESET;
				nxt_addr = `VEC_RESET;
				nxt_rd = 1'b1;
				nxt_state = irq_seq_pkg::ST_VEC_HI;
			end
			irq_seq_pkg::ST_RUN: begin
				if (i_pc_advance) begin
					nxt_pc = i_next_pc;
				end
				if (i_ccr_wr) begin
					nxt_ccr = i_ccr_wdata;
				end else begin
					nxt_ccr = alu_ccr;
				end
				if (i_swi) begin
					nxt_swi_pend = 1'b1;
				end
				if (i_reload_sp) begin
					nxt_sp = `SP_RESET_VALUE;
				end else if (i_push) begin
					nxt_sp = sp_dec;
				end else if (i_pull) begin
					nxt_sp = sp_inc;
				end
				// Only boundaries are checked, never mid-instruction
				if (i_insn_done) begin
					nxt_cnt = 3'h0;
					if (take_hw) begin
						nxt_vec = hw_vec;
						nxt_state = irq_seq_pkg::ST_PUSH;
					end else if (i_swi | swi_pend_ff) begin
						// Hardware requests pending at fetch go first
						nxt_swi_pend = 1'b0;
						nxt_vec = `VEC_SWI;
						nxt_state = irq_seq_pkg::ST_PUSH;
					end else if (i_rti) begin
						nxt_sp = sp_inc;
						nxt_addr = {`STACK_ADDR_HIGH, 2'b11, sp_inc};
						nxt_rd = 1'b1;
						nxt_state = irq_seq_pkg::ST_PULL;
					end else if (i_call) begin
						nxt_call_pc = i_call_target;
						nxt_state = irq_seq_pkg::ST_CALL;
					end
				end
			end
			irq_seq_pkg::ST_PUSH: begin
				// Vector read waits a cycle so the last write is not lost
				if (cnt_ff == `STACK_FRAME_BYTES) begin
					nxt_ccr[`CCR_BIT_I] = 1'b1;
					nxt_addr = vec_ff;
					nxt_rd = 1'b1;
					nxt_state = irq_seq_pkg::ST_VEC_HI;
				end else begin
					// Order: PC low, PC high, index, accumulator, flags
					nxt_addr = {`STACK_ADDR_HIGH, 2'b11, sp_ff};
					nxt_wr = 1'b1;
					nxt_sp = sp_dec;
					case (cnt_ff)
						3'h0: nxt_wdata = pc_ff[7:0];
						3'h1: nxt_wdata = pc_ff[15:8];
						3'h2: nxt_wdata = i_index;
						3'h3: nxt_wdata = i_acc;
						default: nxt_wdata = {3'h7, ccr_ff};
					endcase
					nxt_cnt = cnt_ff + 3'h1;
				end
			end
			irq_seq_pkg::ST_CALL: begin
				nxt_addr = {`STACK_ADDR_HIGH, 2'b11, sp_ff};
				nxt_wr = 1'b1;
				nxt_sp = sp_dec;
				nxt_wdata = (cnt_ff == 3'h0) ? pc_ff[7:0] : pc_ff[15:8];
				nxt_cnt = cnt_ff + 3'h1;
				if (cnt_ff == `CALL_FRAME_BYTES - 3'h1) begin
					nxt_pc = call_pc_ff;
					nxt_state = irq_seq_pkg::ST_RUN;
				end
			end
			irq_seq_pkg::ST_VEC_HI: begin
				// Read data stands the cycle after its strobe
				nxt_addr = vec_ff + 16'h0001;
				nxt_rd = 1'b1;
				nxt_cnt = 3'h0;
				nxt_state = irq_seq_pkg::ST_VEC_LO;
			end
			irq_seq_pkg::ST_VEC_LO: begin
				if (cnt_ff == 3'h0) begin
					nxt_vhi = i_mem_rdata;
					nxt_cnt = 3'h1;
				end else begin
					nxt_pc = {vhi_ff, i_mem_rdata};
					nxt_state = irq_seq_pkg::ST_RUN;
				end
			end
			irq_seq_pkg::ST_PULL: begin
				// Byte of the strobe seen in the last cycle arrives now
				nxt_cnt = cnt_ff + 3'h1;
				case (cnt_ff)
					3'h0: nxt_cnt = 3'h1;
					3'h1: nxt_ccr = i_mem_rdata[4:0];
					3'h2: nxt_racc = i_mem_rdata;
					3'h3: nxt_rix = i_mem_rdata;
					3'h4: nxt_pc[15:8] = i_mem_rdata;
					default: nxt_pc[7:0] = i_mem_rdata;
				endcase
				if (cnt_ff == `STACK_FRAME_BYTES) begin
					nxt_rvalid = 1'b1;
					nxt_state = irq_seq_pkg::ST_RUN;
				end else if (cnt_ff < `STACK_FRAME_BYTES - 3'h1) begin
					nxt_sp = sp_inc;
					nxt_addr = {`STACK_ADDR_HIGH, 2'b11, sp_inc};
					nxt_rd = 1'b1;
				end
			end
			default: nxt_state = irq_seq_pkg::ST_RESET;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_ff <= irq_seq_pkg::ST_RESET;
			pc_ff <= `PC_RESET_VALUE;
			sp_ff <= `SP_RESET_VALUE;
			ccr_ff <= `CCR_RESET;
			cnt_ff <= 3'h0;
			vec_ff <= `VEC_RESET;
			vhi_ff <= 8'h00;
			racc_ff <= 8'h00;
			rix_ff <= 8'h00;
			rvalid_ff <= 1'b0;
			addr_ff <= 16'h0000;
			wdata_ff <= 8'h00;
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			call_pc_ff <= 16'h0000;
			swi_pend_ff <= 1'b0;
			ext_latch_ff <= 1'b0;
		end else if (i_clk_en) begin
			state_ff <= nxt_state;
			pc_ff <= nxt_pc;
			sp_ff <= nxt_sp;
			ccr_ff <= nxt_ccr;
			cnt_ff <= nxt_cnt;
			vec_ff <= nxt_vec;
			vhi_ff <= nxt_vhi;
			racc_ff <= nxt_racc;
			rix_ff <= nxt_rix;
			rvalid_ff <= nxt_rvalid;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			call_pc_ff <= nxt_call_pc;
			swi_pend_ff <= nxt_swi_pend;
			ext_latch_ff <= nxt_ext_latch;
		end
	end

	assign o_pc = pc_ff;
	assign o_mem_addr = addr_ff;
	assign o_mem_wdata = wdata_ff;
	assign o_mem_wr = wr_ff;
	assign o_mem_rd = rd_ff;
	assign o_restore_acc = racc_ff;
	assign o_restore_index = rix_ff;
	assign o_restore_valid = rvalid_ff;
	assign o_condition_flags = ccr_ff;
	assign o_busy = (state_ff != irq_seq_pkg::ST_RUN);
endmodule : cpu_interrupt_sequencing
`default_nettype wire

// *** verilog/irq_seq_consts.svh ***
// Constants for the interrupt and exception sequencer
`ifndef IRQ_SEQ_CONSTS_SVH
`define IRQ_SEQ_CONSTS_SVH
`define PC_RESET_VALUE 16'h0000
`define SP_RESET_VALUE 6'h3f
`define SP_HIGH_PATTERN 8'h03
`define STACK_ADDR_HIGH 8'h00
`define VEC_RESET 16'h3ffe
`define VEC_SWI 16'h3ffc
`define VEC_EXT 16'h3ffa
`define VEC_TIMER 16'h3ff8
`define VEC_ASYNC 16'h3ff6
`define VEC_SYNC 16'h3ff4
`define CCR_RESET 5'h08
`define CCR_BIT_C 0
`define CCR_BIT_Z 1
`define CCR_BIT_N 2
`define CCR_BIT_I 3
`define CCR_BIT_H 4
`define STACK_FRAME_BYTES 3'h5
`define CALL_FRAME_BYTES 3'h2
`define SYNC_STAGES 2
`endif

// *** verilog/irq_seq_pkg.sv ***
// Types for the interrupt and exception sequencer
package irq_seq_pkg;
	typedef enum logic [6:0] {
		ST_RESET = 7'h01,
		ST_RUN = 7'h02,
		ST_PUSH = 7'h04,
		ST_VEC_HI = 7'h08,
		ST_VEC_LO = 7'h10,
		ST_PULL = 7'h20,
		ST_CALL = 7'h40
	} seq_state_e;
	typedef struct packed {
		logic capture_flag;
		logic compare_flag;
		logic overflow_flag;
		logic capture_int_enable;
		logic compare_int_enable;
		logic overflow_int_enable;
	} timer_irq_s;
	typedef struct packed {
		logic transmit_empty_flag;
		logic transmit_complete_flag;
		logic receive_full_flag;
		logic overrun_flag;
		logic idle_flag;
		logic transmit_int_enable;
		logic receive_int_enable;
		logic idle_int_enable;
	} async_irq_s;
	typedef struct packed {
		logic transfer_complete_flag;
		logic mode_fault_flag;
		logic sync_serial_int_enable;
	} sync_irq_s;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic carry_in;
		logic [7:0] result;
		logic upd_h;
		logic upd_nz;
		logic upd_c;
		logic c_value;
	} alu_flags_s;
endpackage : irq_seq_pkg

// *** sim/cpu_interrupt_sequencing_sva.sv ***
// Checker for stacking, vector fetch and pin level of the sequencer
`timescale 1ns/10ps
`default_nettype none
module irq_seq_checker #(
	parameter int PORTB_WIDTH = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_irq_pin_n,
	input wire logic [PORTB_WIDTH-1:0] i_portb_pin,
	input wire logic [PORTB_WIDTH-1:0] i_portb_pullup_en,
	input wire logic [15:0] o_mem_addr,
	input wire logic [7:0] o_mem_wdata,
	input wire logic o_mem_wr,
	input wire logic o_mem_rd,
	input wire logic [4:0] o_condition_flags,
	input wire logic o_pin_level
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	// Even vector read that is not the reset vector marks an entry
	wire vec_even = o_mem_rd && o_mem_addr[15:4] == 12'h3ff && !o_mem_addr[0];
	wire entry_vec = vec_even && o_mem_addr != 16'h3ffe;
	wire lines_high = i_irq_pin_n && &(i_portb_pin | ~i_portb_pullup_en);
	stack_range_a: assert property (o_mem_wr |-> o_mem_addr[15:6] == 10'h003)
		else $error("stack write outside stack page");
	push_desc_a: assert property (o_mem_wr ##1 o_mem_wr |->
		o_mem_addr[5:0] == $past(o_mem_addr[5:0]) - 6'h01)
		else $error("push address did not step down");
	pull_asc_a: assert property (o_mem_rd && o_mem_addr[15:8] == 8'h00 ##1
		o_mem_rd |-> o_mem_addr[5:0] == $past(o_mem_addr[5:0]) + 6'h01)
		else $error("pull address did not step up");
	vec_pair_a: assert property (vec_even |=>
		o_mem_rd && o_mem_addr == $past(o_mem_addr) + 16'h0001)
		else $error("vector low byte not read next");
	entry_push_a: assert property (entry_vec |-> $past(o_mem_wr) &&
		$past(o_mem_wr, 5) && !$past(o_mem_wr, 6))
		else $error("entry did not push five bytes");
	flags_byte_a: assert property (entry_vec |->
		$past(o_mem_wdata[7:5]) == 3'h7)
		else $error("last pushed byte is not the flags byte");
	mask_set_a: assert property (entry_vec |-> ##3 o_condition_flags[3])
		else $error("mask not set after entry");
	reset_vec_a: assert property ($rose(i_reset_n) |->
		##[0:3] (o_mem_rd && o_mem_addr == 16'h3ffe))
		else $error("reset vector not fetched");
	pin_low_a: assert property ((!i_irq_pin_n) [*3] |-> !o_pin_level)
		else $error("pin level missed a low pin");
	pin_high_a: assert property (lines_high [*3] |-> o_pin_level)
		else $error("pin level low with all lines high");
endmodule : irq_seq_checker
bind cpu_interrupt_sequencing irq_seq_checker #(.PORTB_WIDTH(PORTB_WIDTH)) u_chk (
	.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_irq_pin_n(i_irq_pin_n),
	.i_portb_pin(i_portb_pin), .i_portb_pullup_en(i_portb_pullup_en),
	.o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_wr(o_mem_wr),
	.o_mem_rd(o_mem_rd), .o_condition_flags(o_condition_flags),
	.o_pin_level(o_pin_level));
`default_nettype wire

// *** sim/irq_periph_model.sv ***
// Peripheral flags and interrupt pins facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module irq_periph_model (
	input wire logic i_clk_sys,
	input wire logic [4:0] i_fire,
	input wire logic i_en,
	input wire logic [15:0] i_mem_addr,
	input wire logic i_mem_rd,
	output wire logic o_irq_pin_n,
	output wire logic [7:0] o_portb_pin,
	output wire irq_seq_pkg::timer_irq_s o_timer,
	output wire irq_seq_pkg::async_irq_s o_async,
	output wire irq_seq_pkg::sync_irq_s o_sync
);
	logic [2:0] pend_ff = 3'h0;
	logic [2:0] low_ff = 3'h0;
	logic [2:0] lowb_ff = 3'h0;
	// Flag cleared when its vector is fetched, as service software would
	always @(posedge i_clk_sys) begin
		for (int k = 0; k < 3; k++) begin
			if (i_fire[k+1])
				pend_ff[k] <= 1'b1;
			else if (i_mem_rd && i_mem_addr == 16'h3ff8 - 16'(2 * k))
				pend_ff[k] <= 1'b0;
		end
		low_ff <= i_fire[0] ? 3'h7 : low_ff >> 1;
		lowb_ff <= i_fire[4] ? 3'h7 : lowb_ff >> 1;
	end
	// Pins idle high through pull-ups; pulses last three cycles
	assign o_irq_pin_n = !low_ff[0];
	assign o_portb_pin = {7'h7f, !lowb_ff[0]};
	assign o_timer = {pend_ff[0], 2'h0, {3{i_en}}};
	assign o_async = {pend_ff[1], 4'h0, {3{i_en}}};
	assign o_sync = {pend_ff[2], 1'b0, i_en};
endmodule : irq_periph_model
`default_nettype wire

// *** sim/cpu_interrupt_sequencing_bench.sv ***
// Testbench for the interrupt sequencer
`timescale 1ns/10ps
`default_nettype none
module cpu_interrupt_sequencing_bench;
	logic i_clk_sys = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_insn_done = 1'b0, i_rti = 1'b0, i_swi = 1'b0, i_reload_sp = 1'b0;
	logic i_ccr_wr = 1'b0, en = 1'b1, wr_d = 1'b0;
	logic clk_en = 1'b1, compat = 1'b0, soft_eo = 1'b1, prog_eo = 1'b0;
	logic pc_adv = 1'b0;
	logic [7:0] pu = 8'h01, acc_v = 8'h11, idx_v = 8'h22;
	logic [4:0] i_ccr_wdata = 5'h00, fire = 5'h00;
	logic [7:0] i_mem_rdata = 8'h00, stk [256];
	logic [15:0] first_wa = 16'h0000, p;
	irq_seq_pkg::alu_flags_s alu = '0;
	irq_seq_pkg::timer_irq_s tmr;
	irq_seq_pkg::async_irq_s asy;
	irq_seq_pkg::sync_irq_s syn;
	wire irq_n, pin_lvl, busy, mwr, mrd, rvalid;
	wire [7:0] portb, mwd, racc, ridx;
	wire [15:0] o_pc, maddr;
	wire [4:0] flags;
	int miscompares = 0, check_count = 0, cyc = 0;
	always #2.5 i_clk_sys = ~i_clk_sys;
	cpu_interrupt_sequencing u_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.i_clk_en(clk_en), .i_irq_pin_n(irq_n), .i_portb_pin(portb),
		.i_portb_pullup_en(pu), .i_compat_sel(compat), .i_soft_edge_only(soft_eo),
		.i_prog_edge_select_bit(prog_eo), .i_timer(tmr), .i_async(asy),
		.i_sync(syn),
		.i_insn_done(i_insn_done), .i_next_pc(16'h0000), .i_pc_advance(pc_adv),
		.i_swi(i_swi), .i_rti(i_rti), .i_call(1'b0), .i_call_target(16'h0000),
		.i_reload_sp(i_reload_sp), .i_push(1'b0), .i_pull(1'b0), .i_acc(acc_v),
		.i_index(idx_v), .i_mem_rdata(i_mem_rdata), .i_alu(alu),
		.i_ccr_wr(i_ccr_wr), .i_ccr_wdata(i_ccr_wdata), .o_pc(o_pc),
		.o_mem_addr(maddr), .o_mem_wdata(mwd), .o_mem_wr(mwr), .o_mem_rd(mrd),
		.o_restore_acc(racc), .o_restore_index(ridx), .o_restore_valid(rvalid),
		.o_condition_flags(flags), .o_pin_level(pin_lvl), .o_busy(busy));
	irq_periph_model u_periph (.i_clk_sys(i_clk_sys), .i_fire(fire), .i_en(en),
		.i_mem_addr(maddr), .i_mem_rd(mrd), .o_irq_pin_n(irq_n),
		.o_portb_pin(portb), .o_timer(tmr), .o_async(asy), .o_sync(syn));
	// Read data stands one cycle only; otherwise the line shows garbage
	always @(posedge i_clk_sys) begin
		if (mwr)
			stk[maddr[7:0]] <= mwd;
		i_mem_rdata <= !mrd ? ~i_mem_rdata :
			maddr[15:8] == 8'h00 ? stk[maddr[7:0]] : maddr[7:0] ^ 8'h5a;
		wr_d <= mwr;
		if (mwr && !wr_d)
			first_wa <= maddr;
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			miscompares++;
			conclude();
		end
	end
	function automatic logic [15:0] vexp(input logic [15:0] v);
		return {v[7:0] ^ 8'h5a, (v[7:0] + 8'h01) ^ 8'h5a};
	endfunction : vexp
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		check_count++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			miscompares++;
		end
	endtask : chk
	task automatic run();
		repeat (2) @(posedge i_clk_sys);
		#1;
		while (busy !== 1'b0) begin
			@(posedge i_clk_sys);
			#1;
		end
	endtask : run
	task automatic bnd(input logic r, input logic s);
		@(posedge i_clk_sys);
		{i_insn_done, i_rti, i_swi} <= {1'b1, r, s};
		@(posedge i_clk_sys);
		{i_insn_done, i_rti, i_swi} <= 3'h0;
	endtask : bnd
	task automatic condition_flags(input logic [4:0] d);
		@(posedge i_clk_sys);
		{i_ccr_wr, i_ccr_wdata} <= {1'b1, d};
		@(posedge i_clk_sys);
		i_ccr_wr <= 1'b0;
	endtask : condition_flags
	task automatic kick(input logic [4:0] f);
		@(posedge i_clk_sys);
		fire <= f;
		@(posedge i_clk_sys);
		fire <= 5'h00;
		repeat (8) @(posedge i_clk_sys);
	endtask : kick
	task automatic irq(input logic [4:0] f, input logic [15:0] v);
		condition_flags(5'h00);
		kick(f);
		bnd(1'b0, 1'b0);
		run();
		chk("pc", vexp(v), o_pc);
	endtask : irq
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		run();
		p = o_pc;
		chk("reset pc", vexp(16'h3ffe), o_pc);
		chk("reset flags", 16'h0008, 16'(flags));
		irq(5'h02, 16'h3ff8);
		chk("first push", 16'h00ff, first_wa);
		chk("mask", 16'h0001, 16'(flags[3]));
		bnd(1'b1, 1'b0);
		run();
		chk("acc", 16'h0011, 16'(racc));
		chk("index", 16'h0022, 16'(ridx));
		chk("ret pc", p, o_pc);
		chk("ret flags", 16'h0000, 16'(flags));
		$display("test entry and return done");
		condition_flags(5'h08);
		kick(5'h01);
		bnd(1'b0, 1'b0);
		repeat (12) @(posedge i_clk_sys);
		chk("masked pc", p, o_pc);
		irq(5'h00, 16'h3ffa);
		irq(5'h0f, 16'h3ffa);
		irq(5'h00, 16'h3ff8);
		irq(5'h00, 16'h3ff6);
		irq(5'h00, 16'h3ff4);
		irq(5'h10, 16'h3ffa);
		$display("test masking and priority done");
		en <= 1'b0;
		p = o_pc;
		condition_flags(5'h00);
		kick(5'h02);
		bnd(1'b0, 1'b0);
		repeat (12) @(posedge i_clk_sys);
		chk("disabled pc", p, o_pc);
		en <= 1'b1;
		irq(5'h00, 16'h3ff8);
		condition_flags(5'h08);
		bnd(1'b0, 1'b1);
		run();
		chk("swi pc", vexp(16'h3ffc), o_pc);
		// Six more entries overrun the 64-byte stack
		for (int k = 0; k < 6; k++)
			irq(5'h02, 16'h3ff8);
		chk("wrapped push", 16'h00fe, first_wa);
		@(posedge i_clk_sys);
		i_reload_sp <= 1'b1;
		@(posedge i_clk_sys);
		i_reload_sp <= 1'b0;
		irq(5'h02, 16'h3ff8);
		chk("reload push", 16'h00ff, first_wa);
		$display("test stack and software entry done");
		conclude();
	end
endmodule : cpu_interrupt_sequencing_bench
`default_nettype wire
